// *** shared/jtag_host_pkg.sv ***
package jtag_host_pkg;
  // clocks, in ns
  localparam int CLK_PERIOD_NS = 8;
  localparam int TCK_PERIOD_NS = 160;
  localparam int TCK_HALF_CYC = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  // least width of a program pulse
  localparam int PROGRAM_PIN_PULSE_NS = 300;
  localparam int PROGRAM_PIN_PULSE_CYC =
    (PROGRAM_PIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TX = 8'h04;
  localparam logic [7:0] OFS_RX = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_PROGRAM_PIN = 8'h10;

  // ctrl fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_EXIT_BIT = 4;
  localparam int CTRL_CNT_LSB = 8;
  localparam logic [1:0] OP_TLR = 2'h1;
  localparam logic [1:0] OP_IR = 2'h2;
  localparam logic [1:0] OP_DR = 2'h3;

  // status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_INDR_BIT = 1;
  localparam int ST_PROGRAM_PIN_BIT = 2;

  // tms walks, first bit in bit 0
  localparam logic [5:0] TMS_TLR = 6'h1f;
  localparam logic [2:0] TMS_TLR_LEN = 3'h6;
  localparam logic [5:0] TMS_TO_SIR = 6'h03;
  localparam logic [2:0] TMS_TO_SIR_LEN = 3'h4;
  localparam logic [5:0] TMS_TO_SDR = 6'h01;
  localparam logic [2:0] TMS_TO_SDR_LEN = 3'h3;
  localparam logic [5:0] IR_LEN = 6'h05;
  localparam logic [5:0] WORD_LEN = 6'h20;
  localparam logic [1:0] POST_LEN = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hw/tap_bit_engine.sv ***
module tap_bit_engine
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // one bit request
  input wire logic bit_valid,
  input wire logic bit_tms,
  input wire logic bit_tdi,
  output logic bit_ready,
  output logic bit_done,
  output logic bit_tdo,
  // test port pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  localparam int HALF = jtag_host_pkg::TCK_HALF_CYC;

  logic busy_q;
  logic [5:0] cnt_q;
  logic tdo_s1_q;
  logic tdo_s2_q;

  // tck is made here by dividing clk, so it never stops mid-bit
  assign bit_ready = ~busy_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tdo_s1_q <= 1'b0;
      tdo_s2_q <= 1'b0;
    end
    else
    begin
      tdo_s1_q <= tdo;
      tdo_s2_q <= tdo_s1_q;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      busy_q <= 1'b0;
      cnt_q <= 6'h00;
      tck <= 1'b0;
      tms <= 1'b1;
      tdi <= 1'b0;
      bit_done <= 1'b0;
      bit_tdo <= 1'b0;
    end
    else
    begin
      bit_done <= 1'b0;
      if (!busy_q)
      begin
        if (bit_valid)
        begin
          // pins change while tck is low, the device samples on the rise
          busy_q <= 1'b1;
          cnt_q <= 6'h00;
          tms <= bit_tms;
          tdi <= bit_tdi;
        end
      end
      else
      begin
        cnt_q <= cnt_q + 6'h01;
        if (cnt_q == 6'(HALF - 1))
        begin
          // tdo moved on the last fall, so it is settled here
          tck <= 1'b1;
          bit_tdo <= tdo_s2_q;
        end
        if (cnt_q == 6'(2 * HALF - 1))
        begin
          tck <= 1'b0;
          busy_q <= 1'b0;
          bit_done <= 1'b1;
        end
      end
    end
  end

  a_tck_high_time: assert property (@(posedge clk) disable iff (reset)
    $rose(tck) |-> ##9 tck ##1 !tck)
    else $error("tck high phase has the wrong length");

  a_pins_hold_high: assert property (@(posedge clk) disable iff (reset)
    tck |-> $stable(tms) && $stable(tdi))
    else $error("tms or tdi moved while tck was high");
endmodule

// *** hw/jtag_host.sv ***
// Overview of operation
// - load each chained device in turn, passing run-test/idle after each.
// - load startup instruction in all, then twelve tck in shift-DR.
// - program pin stays deasserted while any scan operation runs.
// - shutdown writes option register with shutdown bit one via config-in.
// - data words are shifted most significant bit first.
// - after start command, write crc value or issue crc reset.
// - startup instruction then twelve tck in shift-DR runs the shutdown.
// - clear shutdown bit, shift a zero flush word, return to idle.
// - status capture: reset, config-in, read header plus zero flush.
// - config-out then 32 tck in shift-DR returns the status word.
// - readback writes the start frame address, frame zero for full chip.
// - read command, then read header sized to the wanted frame count.
// - after the read request shift 32 flush bits, then go idle.
// - memory block readback repeats the steps with its own address.
// - config-in instruction shifted rightmost bit first, last bit on exit.
// - startup instruction shifted rightmost bit first, last bit on exit.
// - at power-up tms is held one for five tck edges; reset only sets tms one, the walk needs an OP_TLR command.
module jtag_host
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // test port and program pin
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  output logic program_pin
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PRE = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_POST = 4'b1000
  } seq_state_t;

  seq_state_t state_q;
  logic [5:0] pre_pat_q;
  logic [2:0] pre_cnt_q;
  logic [5:0] sh_cnt_q;
  logic [1:0] post_cnt_q;
  logic exit_q;
  logic in_dr_q;
  logic pending_q;
  logic sample_q;
  logic [31:0] data_q;
  logic [31:0] tx_q;
  logic [31:0] rx_q;
  logic [8:0] program_pin_cnt_q;
  logic bit_valid;
  logic bit_tms;
  logic bit_tdi;
  logic bit_ready;
  logic bit_done;
  logic bit_tdo;
  logic issue;
  logic busy;
  logic wr_go;
  logic rd_go;
  logic ctrl_wr;
  logic [1:0] op;
  logic [5:0] op_cnt;

  function automatic logic [4:0] rev5(input logic [4:0] v);
    rev5 = {v[0], v[1], v[2], v[3], v[4]};
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == jtag_host_pkg::OFS_CTRL) || (a == jtag_host_pkg::OFS_TX)
      || (a == jtag_host_pkg::OFS_RX) || (a == jtag_host_pkg::OFS_STATUS)
      || (a == jtag_host_pkg::OFS_PROGRAM_PIN);
  endfunction

  tap_bit_engine u_engine
  (
    .clk(clk),
    .reset(reset),
    .bit_valid(bit_valid),
    .bit_tms(bit_tms),
    .bit_tdi(bit_tdi),
    .bit_ready(bit_ready),
    .bit_done(bit_done),
    .bit_tdo(bit_tdo),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo)
  );

  assign busy = (state_q != ST_IDLE) || pending_q;
  assign bit_valid = (state_q != ST_IDLE) && !pending_q;
  assign issue = bit_valid && bit_ready;
  assign wr_go = awvalid && wvalid && !awready && !bvalid;
  assign rd_go = arvalid && !arready && !rvalid;
  assign ctrl_wr = wr_go && (awaddr == jtag_host_pkg::OFS_CTRL) && wstrb[0];
  assign op = wdata[jtag_host_pkg::CTRL_OP_LSB +: 2];
  // a count of zero means a full word
  assign op_cnt = (wdata[jtag_host_pkg::CTRL_CNT_LSB +: 6] == 6'h00 ||
    wdata[jtag_host_pkg::CTRL_CNT_LSB +: 6] > jtag_host_pkg::WORD_LEN) ?
    jtag_host_pkg::WORD_LEN : wdata[jtag_host_pkg::CTRL_CNT_LSB +: 6];

  always_comb
  begin
    bit_tms = 1'b0;
    bit_tdi = 1'b0;
    unique case (state_q)
      ST_PRE: bit_tms = pre_pat_q[0];
      ST_SHIFT:
      begin
        bit_tms = exit_q && (sh_cnt_q == 6'h01);
        bit_tdi = data_q[31];
      end
      ST_POST: bit_tms = (post_cnt_q == jtag_host_pkg::POST_LEN);
      default: bit_tms = 1'b0;
    endcase
  end

  // sequencer: prefix walk, shift, then update on exit and back to idle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      pre_pat_q <= 6'h00;
      pre_cnt_q <= 3'h0;
      sh_cnt_q <= 6'h00;
      post_cnt_q <= 2'h0;
      exit_q <= 1'b0;
      in_dr_q <= 1'b0;
      data_q <= 32'h0000_0000;
    end
    else if (state_q == ST_IDLE)
    begin
      // commands are ignored while busy or while program is pulsing
      if (ctrl_wr && !pending_q && program_pin_cnt_q == 9'h000)
      begin
        post_cnt_q <= jtag_host_pkg::POST_LEN;
        if (op == jtag_host_pkg::OP_TLR)
        begin
          state_q <= ST_PRE;
          pre_pat_q <= jtag_host_pkg::TMS_TLR;
          pre_cnt_q <= jtag_host_pkg::TMS_TLR_LEN;
          sh_cnt_q <= 6'h00;
          exit_q <= 1'b0;
          in_dr_q <= 1'b0;
        end
        else if (op == jtag_host_pkg::OP_IR && !in_dr_q)
        begin
          state_q <= ST_PRE;
          pre_pat_q <= jtag_host_pkg::TMS_TO_SIR;
          pre_cnt_q <= jtag_host_pkg::TMS_TO_SIR_LEN;
          sh_cnt_q <= jtag_host_pkg::IR_LEN;
          exit_q <= 1'b1;
          data_q <= {rev5(tx_q[4:0]), 27'h0};
        end
        else if (op == jtag_host_pkg::OP_DR)
        begin
          // words of one stream may follow without leaving shift-DR
          state_q <= in_dr_q ? ST_SHIFT : ST_PRE;
          pre_pat_q <= jtag_host_pkg::TMS_TO_SDR;
          pre_cnt_q <= jtag_host_pkg::TMS_TO_SDR_LEN;
          sh_cnt_q <= op_cnt;
          exit_q <= wdata[jtag_host_pkg::CTRL_EXIT_BIT];
          in_dr_q <= !wdata[jtag_host_pkg::CTRL_EXIT_BIT];
          data_q <= tx_q;
        end
      end
    end
    else if (issue)
    begin
      unique case (state_q)
        ST_PRE:
        begin
          pre_pat_q <= {1'b0, pre_pat_q[5:1]};
          pre_cnt_q <= pre_cnt_q - 3'h1;
          if (pre_cnt_q == 3'h1)
            state_q <= (sh_cnt_q != 6'h00) ? ST_SHIFT : ST_IDLE;
        end
        ST_SHIFT:
        begin
          data_q <= {data_q[30:0], 1'b0};
          sh_cnt_q <= sh_cnt_q - 6'h01;
          if (sh_cnt_q == 6'h01)
            state_q <= exit_q ? ST_POST : ST_IDLE;
        end
        ST_POST:
        begin
          post_cnt_q <= post_cnt_q - 2'h1;
          if (post_cnt_q == 2'h1)
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // one bit in flight; tdo of shift bits is gathered first bit highest
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pending_q <= 1'b0;
      sample_q <= 1'b0;
      rx_q <= 32'h0000_0000;
    end
    else
    begin
      if (issue)
      begin
        pending_q <= 1'b1;
        sample_q <= (state_q == ST_SHIFT);
      end
      else if (bit_done)
        pending_q <= 1'b0;
      if (bit_done && sample_q)
        rx_q <= {rx_q[30:0], bit_tdo};
    end
  end

  // program pulse, only accepted while the scan port is idle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      program_pin_cnt_q <= 9'h000;
      program_pin <= 1'b0;
    end
    else
    begin
      if (program_pin_cnt_q != 9'h000)
        program_pin_cnt_q <= program_pin_cnt_q - 9'h001;
      else if (wr_go && awaddr == jtag_host_pkg::OFS_PROGRAM_PIN && wstrb[0] &&
        wdata[0] && !busy)
        program_pin_cnt_q <= 9'(jtag_host_pkg::PROGRAM_PIN_PULSE_CYC);
      // high for the full count, so the pulse is never below its least width
      program_pin <= (program_pin_cnt_q != 9'h000);
    end
  end

  // axi4-lite slave: address and data are taken together
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= jtag_host_pkg::RESP_OKAY;
      tx_q <= 32'h0000_0000;
    end
    else
    begin
      awready <= wr_go;
      wready <= wr_go;
      if (wr_go)
      begin
        bvalid <= 1'b1;
        bresp <= mapped(awaddr) ? jtag_host_pkg::RESP_OKAY :
          jtag_host_pkg::RESP_SLVERR;
        if (awaddr == jtag_host_pkg::OFS_TX)
        begin
          for (int i = 0; i < 4; i++)
            if (wstrb[i])
              tx_q[8 * i +: 8] <= wdata[8 * i +: 8];
        end
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= jtag_host_pkg::RESP_OKAY;
    end
    else
    begin
      arready <= rd_go;
      if (rd_go)
      begin
        rvalid <= 1'b1;
        rresp <= mapped(araddr) ? jtag_host_pkg::RESP_OKAY :
          jtag_host_pkg::RESP_SLVERR;
        rdata <= 32'h0000_0000;
        unique case (araddr)
          jtag_host_pkg::OFS_TX: rdata <= tx_q;
          jtag_host_pkg::OFS_RX: rdata <= rx_q;
          jtag_host_pkg::OFS_STATUS:
          begin
            rdata[jtag_host_pkg::ST_BUSY_BIT] <= busy;
            rdata[jtag_host_pkg::ST_INDR_BIT] <= in_dr_q;
            rdata[jtag_host_pkg::ST_PROGRAM_PIN_BIT] <= program_pin;
          end
          default: rdata <= 32'h0000_0000;
        endcase
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  a_program_pin_when_idle: assert property (@(posedge clk) disable iff (reset)
    program_pin |-> state_q == ST_IDLE && !pending_q)
    else $error("program pin asserted during a scan operation");

  a_tlr_walk: assert property (@(posedge clk) disable iff (reset)
    (state_q == ST_IDLE && !pending_q && ctrl_wr && op == 2'h1 &&
    program_pin_cnt_q == 9'h000) |=> state_q == ST_PRE && pre_cnt_q == 3'h6 &&
    pre_pat_q == 6'h1f)
    else $error("reset walk not five ones then idle");

  a_shift_msb_first: assert property (@(posedge clk) disable iff (reset)
    issue && state_q == ST_SHIFT && sh_cnt_q != 6'h01 |=>
    data_q[31] == $past(data_q[30]))
    else $error("data not shifted most significant bit first");

  a_rx_capture: assert property (@(posedge clk) disable iff (reset)
    bit_done && sample_q |=> rx_q[0] == $past(bit_tdo) &&
    rx_q[31:1] == $past(rx_q[30:0]))
    else $error("tdo bit not gathered into rx");

  a_busy_refuse: assert property (@(posedge clk) disable iff (reset)
    state_q == ST_SHIFT && ctrl_wr && !issue |=> $stable(sh_cnt_q))
    else $error("command taken while a shift was running");

  a_bresp_hold: assert property (@(posedge clk) disable iff (reset)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before it was taken");
endmodule

// *** tb/cfg_device_model.sv ***
module cfg_device_model
#(
  parameter logic [4:0] CFG_OUT_IR = 5'h04,
  parameter logic [4:0] CFG_IN_IR = 5'h05,
  // packet words of the model's own command set, values arbitrary
  parameter logic [31:0] HOLD_CMD = 32'h0000_00a1,
  parameter logic [31:0] RB_HDR = 32'h0000_00b1,
  parameter int FRAME_WORDS = 2,
  parameter logic [31:0] DATA_BASE = 32'h0000_5a00
)
(
  // test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  // device pins
  input wire logic program_pin,
  input wire logic crc_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  // next state per state, four bits each: tms high, then tms low
  localparam logic [63:0] NX_HI = 64'h2fef_cc02_8785_5920;
  localparam logic [63:0] NX_LO = 64'h1bdd_bba1_4664_4311;
  logic [3:0] st_q = 4'h0;
  logic [4:0] ir_sh_q = 5'h00;
  logic [4:0] ir_q = 5'h00;
  logic [31:0] dr_q = 32'h0;
  logic [4:0] bit_q = 5'h00;
  logic [4:0] su_q = 5'h00;
  logic done_q = 1'b0;
  logic out_q = 1'b1;
  logic en_q = 1'b0;
  logic hold_n_q = 1'b1;
  logic rb_on_q = 1'b0;
  int rb_idx_q = 0;
  logic [31:0] words[$];

  // one dummy word and one dummy frame lead the frame data
  function automatic logic [31:0] rb_word(input int idx);
    rb_word = (idx <= FRAME_WORDS) ? 32'h0 : DATA_BASE + 32'(idx);
  endfunction
  // setup status stays high: no error shown in scan mode
  wire logic [31:0] status = {29'h0, 1'b1, done_q, crc_bad};

  always @(posedge tck or posedge program_pin)
  begin
    if (program_pin)
    begin
      done_q <= 1'b0;
      su_q <= 5'h00;
      hold_n_q <= 1'b1;
      rb_on_q <= 1'b0;
    end
    else
    begin
      st_q <= tms ? NX_HI[st_q*4+:4] : NX_LO[st_q*4+:4];
      case (st_q)
        4'd3:
        begin
          // config-out captures readback once armed, status otherwise
          if (ir_q != CFG_OUT_IR)
            dr_q <= 32'h0;
          else
            dr_q <= rb_on_q ? rb_word(0) : status;
          rb_idx_q <= 1;
          bit_q <= 5'h00;
        end
        4'd4:
        begin
          dr_q <= {dr_q[30:0], tdi};
          bit_q <= bit_q + 5'h01;
          // words only accumulate: memory is never cleared on load
          if (bit_q == 5'h1f)
          begin
            words.push_back({dr_q[30:0], tdi});
            if (ir_q == CFG_IN_IR && {dr_q[30:0], tdi} == HOLD_CMD)
              hold_n_q <= 1'b0;
            if (ir_q == CFG_IN_IR && {dr_q[30:0], tdi} == RB_HDR)
              rb_on_q <= 1'b1;
            if (ir_q == CFG_OUT_IR && rb_on_q)
            begin
              dr_q <= rb_word(rb_idx_q);
              rb_idx_q <= rb_idx_q + 1;
            end
          end
          if (ir_q == 5'h0c)
          begin
            su_q <= su_q + 5'h01;
            done_q <= done_q | (su_q == 5'h0b);
          end
        end
        4'd10: ir_sh_q <= 5'h01;
        4'd11: ir_sh_q <= {tdi, ir_sh_q[4:1]};
        4'd15:
        begin
          ir_q <= ir_sh_q;
          su_q <= 5'h00;
        end
        default: ;
      endcase
    end
  end

  always @(negedge tck)
  begin
    out_q <= (st_q == 4'd11) ? ir_sh_q[0] : dr_q[31];
    en_q <= (st_q == 4'd11) || (st_q == 4'd4);
  end
  // released line floats to its pull-up level
  assign tdo = en_q ? out_q : 1'b1;
endmodule

// *** tb/tb_jtag_host.sv ***
module tb_jtag_host;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic crc_bad = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic tck, tms, tdi, tdo, program_pin;
  int errors = 0;
  int comparisons = 0;
  int program_pin_cyc = 0;
  // packet words of the model's command set, values arbitrary
  localparam logic [31:0] HOLD_CMD = 32'h0000_00a1;
  localparam logic [31:0] RD_CMD = 32'h0000_00a2;
  localparam logic [31:0] RB_HDR = 32'h0000_00b1;
  localparam int FRAME_WORDS = 2;
  localparam logic [31:0] DATA_BASE = 32'h0000_5a00;

  jtag_host i_dut (.clk(clk), .reset(reset), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .program_pin(program_pin));
  cfg_device_model #(.HOLD_CMD(HOLD_CMD), .RB_HDR(RB_HDR),
    .FRAME_WORDS(FRAME_WORDS), .DATA_BASE(DATA_BASE))
    i_dev (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .program_pin(program_pin), .crc_bad(crc_bad));

  always #4 clk = ~clk;

  task automatic close_out;
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw_open;
    logic w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // each channel lets go only when its own ready is seen
    while (aw_open || w_open)
    begin
      @(posedge clk);
      if (aw_open && awready === 1'b1)
      begin
        aw_open = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_open && wready === 1'b1)
      begin
        w_open = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic op(input logic [1:0] code, input logic ex,
    input logic [5:0] n, input logic [31:0] tx);
    axw(jtag_host_pkg::OFS_TX, tx);
    axw(jtag_host_pkg::OFS_CTRL, {18'h0, n, 3'h0, ex, 2'h0, code});
    do axr(jtag_host_pkg::OFS_STATUS); while (rd[0] !== 1'b0);
  endtask

  // a program pulse must never overlap a scan bit
  always @(posedge tck)
    chk("program pin in scan", 32'h0, {31'h0, program_pin});
  always @(posedge clk)
    if (program_pin === 1'b1)
      program_pin_cyc++;

  task automatic t_reset;
    chk("pins after reset", 32'h4, {28'h0, tck, tms, tdi, program_pin});
    axr(jtag_host_pkg::OFS_STATUS);
    chk("status after reset", 32'h0, rd);
    axr(8'h14);
    chk("unmapped read resp", 32'h2, {30'h0, rs});
    axw(8'h14, 32'h1);
    chk("unmapped write resp", 32'h2, {30'h0, rs});
  endtask

  task automatic t_walk;
    op(jtag_host_pkg::OP_IR, 1'b0, 6'h00, 32'h0c);
    op(jtag_host_pkg::OP_TLR, 1'b0, 6'h00, 32'h0);
    chk("state after reset walk", 32'h1, {28'h0, i_dev.st_q});
    op(jtag_host_pkg::OP_IR, 1'b0, 6'h00, 32'h05);
    chk("config-in loaded", 32'h05, {27'h0, i_dev.ir_q});
    chk("state after ir", 32'h1, {28'h0, i_dev.st_q});
  endtask

  task automatic t_status(input logic c, input logic dn);
    int base;
    crc_bad <= c;
    base = i_dev.words.size();
    op(jtag_host_pkg::OP_TLR, 1'b0, 6'h00, 32'h0);
    op(jtag_host_pkg::OP_IR, 1'b0, 6'h00, 32'h05);
    op(jtag_host_pkg::OP_DR, 1'b0, 6'h20, 32'h2800e001);
    axr(jtag_host_pkg::OFS_STATUS);
    chk("held in shift-dr", 32'h2, rd);
    op(jtag_host_pkg::OP_DR, 1'b1, 6'h20, 32'h0);
    chk("header word", 32'h2800e001, i_dev.words[base]);
    chk("flush word", 32'h0, i_dev.words[base+1]);
    op(jtag_host_pkg::OP_IR, 1'b0, 6'h00, 32'h04);
    op(jtag_host_pkg::OP_DR, 1'b1, 6'h20, 32'hffffffff);
    axr(jtag_host_pkg::OFS_RX);
    chk("status word", {29'h0, 1'b1, dn, c}, rd);
  endtask

  task automatic t_startup;
    chk("done before startup", 32'h0, {31'h0, i_dev.done_q});
    op(jtag_host_pkg::OP_IR, 1'b0, 6'h00, 32'h0c);
    chk("startup loaded", 32'h0c, {27'h0, i_dev.ir_q});
    op(jtag_host_pkg::OP_DR, 1'b1, 6'h0c, 32'h0);
    chk("startup tck count", 32'hc, {27'h0, i_dev.su_q});
    chk("done after startup", 32'h1, {31'h0, i_dev.done_q});
  endtask

  task automatic t_readback;
    op(jtag_host_pkg::OP_IR, 1'b0, 6'h00, 32'h05);
    op(jtag_host_pkg::OP_DR, 1'b0, 6'h00, HOLD_CMD);
    chk("hold asserted", 32'h0, {31'h0, i_dev.hold_n_q});
    op(jtag_host_pkg::OP_DR, 1'b0, 6'h20, 32'h0);
    op(jtag_host_pkg::OP_DR, 1'b0, 6'h20, RD_CMD);
    op(jtag_host_pkg::OP_DR, 1'b0, 6'h20, RB_HDR);
    op(jtag_host_pkg::OP_DR, 1'b1, 6'h20, 32'h0);
    op(jtag_host_pkg::OP_IR, 1'b0, 6'h00, 32'h04);
    for (int i = 0; i <= FRAME_WORDS; i++)
    begin
      op(jtag_host_pkg::OP_DR, 1'b0, 6'h20, 32'h0);
      axr(jtag_host_pkg::OFS_RX);
      chk("dummy word", 32'h0, rd);
    end
    op(jtag_host_pkg::OP_DR, 1'b1, 6'h20, 32'h0);
    axr(jtag_host_pkg::OFS_RX);
    chk("frame data", DATA_BASE + FRAME_WORDS + 1, rd);
  endtask

  task automatic t_program_pin;
    // a running shift refuses both a new command and a program pulse
    axw(jtag_host_pkg::OFS_CTRL, 32'h0000_0803);
    axw(jtag_host_pkg::OFS_PROGRAM_PIN, 32'h1);
    repeat (100) @(posedge clk);
    axw(jtag_host_pkg::OFS_CTRL, 32'h1);
    do axr(jtag_host_pkg::OFS_STATUS); while (rd[0] !== 1'b0);
    chk("program while busy", 32'h2, rd);
    chk("command during shift", 32'h4, {28'h0, i_dev.st_q});
    op(jtag_host_pkg::OP_TLR, 1'b0, 6'h00, 32'h0);
    program_pin_cyc = 0;
    axw(jtag_host_pkg::OFS_PROGRAM_PIN, 32'h1);
    axr(jtag_host_pkg::OFS_STATUS);
    chk("program status", 32'h4, rd);
    op(jtag_host_pkg::OP_IR, 1'b0, 6'h00, 32'h0c);
    do axr(jtag_host_pkg::OFS_STATUS); while (rd !== 32'h0);
    chk("ir kept over pulse", 32'h04, {27'h0, i_dev.ir_q});
    chk("pulse length", jtag_host_pkg::PROGRAM_PIN_PULSE_CYC, program_pin_cyc);
    chk("done cleared", 32'h0, {31'h0, i_dev.done_q});
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_walk();
    t_status(1'b0, 1'b0);
    t_startup();
    t_status(1'b1, 1'b1);
    t_readback();
    t_program_pin();
    close_out();
  end

  // whole run is some 16k cycles; allow about three times that
  initial
  begin
    #400us;
    errors++;
    close_out();
  end
endmodule
